/* File: tclw_defs.vh */
`ifndef TCLW_DEFS_VH
`define TCLW_DEFS_VH

// Register indices as printed; byte address on the bus is four times the index.
`define TCLW_IDX_SELF_TEST 8'h14
`define TCLW_IDX_LEVEL 8'h15
`define TCLW_IDX_WATCHDOG 8'h16
`define TCLW_IDX_RESET 8'h01
`define TCLW_IDX_CHANNEL 8'h30

// Reset values.
`define TCLW_RST_SELF_TEST 8'h00
`define TCLW_RST_LEVEL 8'h01
`define TCLW_RST_WATCHDOG 8'hFE
`define TCLW_RST_LEVEL_SEL 1'b1

// Field positions.
`define TCLW_SELF_TEST_EN_BIT 0
`define TCLW_OSC_SEL_HI 2
`define TCLW_OSC_SEL_LO 1
`define TCLW_WD_DISABLE_BIT 0
`define TCLW_WD_TIMEOUT_HI 7
`define TCLW_WD_TIMEOUT_LO 1
`define TCLW_RESET_DIG0_BIT 0
`define TCLW_RESET_DIG1_BIT 1

// Level-select keys.
`define TCLW_KEY_SET 8'hB5
`define TCLW_KEY_CLEAR 8'hB6

// Frame oscillator codes on the output.
`define TCLW_OSC_EXT_PIXEL 3'h0
`define TCLW_OSC_25 3'h1
`define TCLW_OSC_33 3'h2
`define TCLW_OSC_50 3'h3
`define TCLW_OSC_100 3'h4
`define TCLW_OSC_VIDEO 3'h5

// Watchdog timing: step of 2 ms at 25 MHz.
`define TCLW_CLK_HZ 25000000
`define TCLW_WD_STEP_US 2000
`define TCLW_WD_STEP_CYCLES ((`TCLW_CLK_HZ / 1000000) * `TCLW_WD_STEP_US)

// Strap capture: edges after reset release until the synchroniser holds the pin.
`define TCLW_STRAP_CAPTURE_CNT 2'h2
`define TCLW_STRAP_DONE_CNT 2'h3

`endif

/* File: tclw_sync2.v */
`timescale 1ns/10ps
`default_nettype none

module tclw_sync2 (
  input wire CLK,
  input wire RST,
  input wire din,
  output reg dout
);

  reg meta_q;

  always @(posedge CLK) begin
    if (RST) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule // tclw_sync2

`default_nettype wire

/* File: tclw_watchdog.v */
`timescale 1ns/10ps
`default_nettype none

`include "tclw_defs.vh"

// Counts 2 ms steps during one control channel transaction.
module tclw_watchdog #(
  parameter STEP_CYCLES = `TCLW_WD_STEP_CYCLES
) (
  input wire CLK,
  input wire RST,
  input wire disable_wd,
  input wire [6:0] timeout,
  input wire txn_start,
  input wire txn_done,
  output reg abort,
  output reg busy
);

  reg [31:0] pre_q;
  reg [6:0] steps_q;
  wire tick;

  assign tick = (pre_q == STEP_CYCLES - 1);

  always @(posedge CLK) begin
    if (RST) begin
      pre_q <= 32'h0;
      steps_q <= 7'h00;
      abort <= 1'b0;
      busy <= 1'b0;
    end else begin
      abort <= 1'b0;
      if (disable_wd) begin
        busy <= 1'b0;
        pre_q <= 32'h0;
        steps_q <= 7'h00;
      end else if (txn_start) begin
        busy <= 1'b1;
        pre_q <= 32'h0;
        steps_q <= 7'h00;
      end else if (txn_done) begin
        busy <= 1'b0;
        pre_q <= 32'h0;
        steps_q <= 7'h00;
      end else if (busy) begin
        pre_q <= tick ? 32'h0 : pre_q + 32'h1;
        if (tick) begin
          // A zero timeout still aborts after the first step rather than never.
          if (steps_q + 7'h01 >= timeout) begin
            abort <= 1'b1;
            busy <= 1'b0;
            steps_q <= 7'h00;
          end else begin
            steps_q <= steps_q + 7'h01;
          end
        end
      end
    end
  end

endmodule // tclw_watchdog

`default_nettype wire

/* File: tclw_regs.v */
// Function
// - In functional mode with the video clock missing and the enable bit set, source code 00/01 picks 50 MHz, 10 picks 100 MHz, 11 picks 25 MHz.
// - With self-test enabled the same field picks external pixel clock (00), 33 MHz (01) or 100 MHz (1x); self-test is off at reset.
// - The level strap sampled at power-up sets the level bit, low meaning 3.3 V and high meaning 1.8 V.
// - Either digital reset written to the reset register forces the level back to 3.3 V.
// - Reading the level register returns 1 for 3.3 V and 0 for 1.8 V.
// - Of writes to the level register, only the 8-bit keys 0xB5 (set) and 0xB6 (clear) change the level bit.
// - Each control channel transaction is watched and aborted when it exceeds the timeout.
// - The timeout is the field in bits 7:1 in 2 ms steps, resetting to 0x7F.
// - The watchdog runs while bit 0 of its register is 0 and stops while it is 1.
`timescale 1ns/10ps
`default_nettype none

`include "tclw_defs.vh"

module tclw_regs #(
  parameter WD_STEP_CYCLES = `TCLW_WD_STEP_CYCLES
) (
  input wire CLK,
  input wire RST,
  input wire [31:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_WE_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  output reg WB_ERR_O,
  input wire LEVEL_STRAP,
  input wire VIDEO_CLK_PRESENT,
  input wire OSC_OVERRIDE_EN,
  input wire TXN_START,
  input wire TXN_DONE,
  output reg [2:0] FRAME_OSC_SEL,
  output reg SELF_TEST_EN,
  output reg LEVEL_SEL_3V3,
  output reg DIGITAL_RESET,
  output reg WD_ABORT,
  output reg WD_BUSY
);

  reg [7:0] self_test_q;
  reg level_q;
  reg [7:0] watchdog_q;
  reg [1:0] strap_cnt_q;
  reg [2:0] osc_d;
  reg [31:0] rdata_d;
  reg hit_d;
  wire strap_s;
  wire video_s;
  wire wd_abort;
  wire wd_busy;
  wire [7:0] idx;
  wire req;
  wire wr_byte;
  wire [7:0] wbyte;

  // The strap and video-clock pins pass two flip-flops before use.
  tclw_sync2 u_sync_strap (
    .CLK(CLK),
    .RST(RST),
    .din(LEVEL_STRAP),
    .dout(strap_s)
  );

  tclw_sync2 u_sync_video (
    .CLK(CLK),
    .RST(RST),
    .din(VIDEO_CLK_PRESENT),
    .dout(video_s)
  );

  tclw_watchdog #(
    .STEP_CYCLES(WD_STEP_CYCLES)
  ) u_watchdog (
    .CLK(CLK),
    .RST(RST),
    .disable_wd(watchdog_q[`TCLW_WD_DISABLE_BIT]),
    .timeout(watchdog_q[`TCLW_WD_TIMEOUT_HI:`TCLW_WD_TIMEOUT_LO]),
    .txn_start(TXN_START),
    .txn_done(TXN_DONE),
    .abort(wd_abort),
    .busy(wd_busy)
  );

  assign idx = WB_ADR_I[9:2];
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign wr_byte = req && WB_WE_I && WB_SEL_I[0];
  assign wbyte = WB_DAT_I[7:0];

  always @* begin
    hit_d = 1'b1;
    rdata_d = 32'h0;
    if (WB_ADR_I[1:0] != 2'h0 || WB_ADR_I[31:10] != 22'h0) begin
      hit_d = 1'b0;
    end else begin
      case (idx)
        `TCLW_IDX_SELF_TEST: rdata_d = {24'h0, self_test_q};
        `TCLW_IDX_LEVEL: rdata_d = {31'h0, level_q};
        `TCLW_IDX_WATCHDOG: rdata_d = {24'h0, watchdog_q};
        `TCLW_IDX_RESET: rdata_d = 32'h0;
        `TCLW_IDX_CHANNEL: rdata_d = {30'h0, wd_busy, 1'b0};
        default: hit_d = 1'b0;
      endcase
    end
  end

  always @* begin
    osc_d = `TCLW_OSC_VIDEO;
    if (self_test_q[`TCLW_SELF_TEST_EN_BIT]) begin
      case (self_test_q[`TCLW_OSC_SEL_HI:`TCLW_OSC_SEL_LO])
        2'h0: osc_d = `TCLW_OSC_EXT_PIXEL;
        2'h1: osc_d = `TCLW_OSC_33;
        default: osc_d = `TCLW_OSC_100;
      endcase
    end else if (!video_s && OSC_OVERRIDE_EN) begin
      case (self_test_q[`TCLW_OSC_SEL_HI:`TCLW_OSC_SEL_LO])
        2'h2: osc_d = `TCLW_OSC_100;
        2'h3: osc_d = `TCLW_OSC_25;
        default: osc_d = `TCLW_OSC_50;
      endcase
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      self_test_q <= `TCLW_RST_SELF_TEST;
      level_q <= `TCLW_RST_LEVEL_SEL;
      watchdog_q <= `TCLW_RST_WATCHDOG;
      strap_cnt_q <= 2'h0;
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h0;
      DIGITAL_RESET <= 1'b0;
      FRAME_OSC_SEL <= `TCLW_OSC_VIDEO;
      SELF_TEST_EN <= 1'b0;
      LEVEL_SEL_3V3 <= `TCLW_RST_LEVEL_SEL;
      WD_ABORT <= 1'b0;
      WD_BUSY <= 1'b0;
    end else begin
      WB_ACK_O <= req && hit_d;
      WB_ERR_O <= req && !hit_d;
      WB_DAT_O <= (req && hit_d && !WB_WE_I) ? rdata_d : 32'h0;
      DIGITAL_RESET <= 1'b0;
      // The synchroniser is cleared by reset too, so the strap is taken on the
      // third edge after release, once the second flop holds the pin value.
      // A keyed or reset write that lands first wins and cancels the capture.
      if (strap_cnt_q != `TCLW_STRAP_DONE_CNT) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      if (strap_cnt_q == `TCLW_STRAP_CAPTURE_CNT) begin
        level_q <= ~strap_s;
      end
      if (wr_byte && hit_d) begin
        case (idx)
          `TCLW_IDX_SELF_TEST: self_test_q <= {5'h00, wbyte[2:0]};
          `TCLW_IDX_WATCHDOG: watchdog_q <= wbyte;
          `TCLW_IDX_LEVEL: begin
            // Keys only; any other byte is ignored so a stray write cannot
            // flip the pad level.
            if (wbyte == `TCLW_KEY_SET) begin
              level_q <= 1'b1;
              strap_cnt_q <= `TCLW_STRAP_DONE_CNT;
            end else if (wbyte == `TCLW_KEY_CLEAR) begin
              level_q <= 1'b0;
              strap_cnt_q <= `TCLW_STRAP_DONE_CNT;
            end
          end
          `TCLW_IDX_RESET: begin
            if (wbyte[`TCLW_RESET_DIG0_BIT] || wbyte[`TCLW_RESET_DIG1_BIT]) begin
              level_q <= 1'b1;
              strap_cnt_q <= `TCLW_STRAP_DONE_CNT;
              DIGITAL_RESET <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      FRAME_OSC_SEL <= osc_d;
      SELF_TEST_EN <= self_test_q[`TCLW_SELF_TEST_EN_BIT];
      LEVEL_SEL_3V3 <= level_q;
      WD_ABORT <= wd_abort;
      WD_BUSY <= wd_busy;
    end
  end

endmodule // tclw_regs

`default_nettype wire

/* File: tclw_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module tclw_asserts #(
  parameter WD_STEP_CYCLES = 4
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic TXN_START,
  input wire logic TXN_DONE,
  input wire logic LEVEL_SEL_3V3,
  input wire logic DIGITAL_RESET,
  input wire logic WD_ABORT,
  input wire logic WD_BUSY
);
  logic off_q;
  logic [6:0] to_q;
  logic [2:0] age_q;
  // The strap settles through a synchroniser, so early level moves are exempt.
  always_ff @(posedge CLK) begin
    if (RST) begin
      off_q <= 1'h0;
      to_q <= 7'h7F;
      age_q <= 3'h0;
    end else begin
      if (age_q != 3'h7) age_q <= age_q + 3'h1;
      if (WB_ACK_O && WB_WE_I && WB_ADR_I[7:0] == 8'h58) begin
        off_q <= WB_DAT_I[0];
        to_q <= WB_DAT_I[7:1];
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_wr(logic [7:0] a, logic [7:0] k);
    WB_ACK_O && WB_WE_I && WB_ADR_I[7:0] == a && WB_DAT_I[7:0] == k;
  endsequence
  AST_LEVEL_SET: assert property (s_wr(8'h54, 8'hB5) |=> LEVEL_SEL_3V3)
    else $error("level key set ignored");
  AST_LEVEL_CLR: assert property (s_wr(8'h54, 8'hB6) |=> !LEVEL_SEL_3V3)
    else $error("level key clear ignored");
  AST_LEVEL_HOLD: assert property (age_q == 3'h7 && $changed(LEVEL_SEL_3V3) |->
    $past(WB_ACK_O && WB_WE_I && (WB_ADR_I[7:0] == 8'h54 || WB_ADR_I[7:0] == 8'h04)))
    else $error("level moved");
  AST_DRST_LEVEL: assert property (DIGITAL_RESET |-> ##[0:2] LEVEL_SEL_3V3)
    else $error("digital reset kept 1.8 V");
  AST_READ_LEVEL: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[7:0] == 8'h54 |->
    WB_DAT_O == {31'h0, LEVEL_SEL_3V3}) else $error("level readback wrong");
  AST_WD_START: assert property (TXN_START && !off_q |-> ##2 WD_BUSY)
    else $error("watchdog not started");
  AST_WD_DONE: assert property (TXN_DONE && !TXN_START |-> ##2 !WD_BUSY)
    else $error("watchdog not cleared");
  AST_WD_OFF: assert property (off_q && $past(off_q) |-> !WD_BUSY && !WD_ABORT)
    else $error("disabled watchdog active");
  AST_WD_ABORT: assert property (TXN_START && !off_q && to_q == 7'h01 ##1
    (!TXN_START && !TXN_DONE) [*4] |-> ##[0:4] WD_ABORT) else $error("no abort");
endmodule // tclw_asserts
bind tclw_regs tclw_asserts #(.WD_STEP_CYCLES(WD_STEP_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: tclw_far.sv */
`timescale 1ns/10ps
`default_nettype none
module tclw_far (
  input wire logic CLK,
  input wire logic go,
  input wire logic [7:0] lat,
  output var logic start,
  output var logic done
);
  int n = 0;
  // A latency of zero never completes, which stalls the channel on purpose.
  always @(posedge CLK) begin
    start <= go;
    done <= n == 1;
    if (go) n <= lat;
    else if (n > 0) n <= n - 1;
  end
endmodule // tclw_far
`default_nettype wire

/* File: test_test_clock_level_watchdog_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module test_test_clock_level_watchdog_regs;
  logic clk = 1'h0, rst = 1'h1, we = 1'h0, cyc = 1'h0, strap = 1'h1, vid = 1'h0, go = 1'h0;
  logic ovr = 1'h1;
  logic [31:0] adr = 32'h0, dat = 32'h0, rdat;
  logic [7:0] lat = 8'h0;
  logic ack, err, st_en, lvl, drst, abort, busy, ts, td;
  logic [2:0] osc;
  logic [2:0] osc_exp [8] = '{3'h3, 3'h3, 3'h4, 3'h1, 3'h0, 3'h2, 3'h4, 3'h4};
  int n_mismatch = 0, n_checks = 0, n_abort = 0, n_drst = 0, i;
  always #20 clk = ~clk;
  always @(posedge clk) if (abort === 1'h1) n_abort <= n_abort + 1;
  always @(posedge clk) if (drst === 1'h1) n_drst <= n_drst + 1;
  tclw_regs #(.WD_STEP_CYCLES(4)) dut_u (.CLK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WB_ERR_O(err), .LEVEL_STRAP(strap), .VIDEO_CLK_PRESENT(vid),
    .OSC_OVERRIDE_EN(ovr), .TXN_START(ts), .TXN_DONE(td), .FRAME_OSC_SEL(osc),
    .SELF_TEST_EN(st_en), .LEVEL_SEL_3V3(lvl), .DIGITAL_RESET(drst), .WD_ABORT(abort),
    .WD_BUSY(busy));
  tclw_far far_u (.CLK(clk), .go(go), .lat(lat), .start(ts), .done(td));
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input bit c, input string m);
    n_checks++;
    if (!c) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [7:0] e,
      input logic er);
    int k;
    @(posedge clk);
    adr <= {24'h0, a};
    we <= w;
    dat <= {24'h0, d};
    cyc <= 1'h1;
    for (k = 0; k < 20 && ack !== 1'h1 && err !== 1'h1; k++) @(posedge clk);
    cyc <= 1'h0;
    chk(k < 20 && err === er && (w || rdat === {24'h0, e}), "bus access");
    if (k >= 20) give_verdict();
  endtask
  task automatic txn(input logic [7:0] l, input int ea);
    @(posedge clk);
    go <= 1'h1;
    lat <= l;
    @(posedge clk);
    go <= 1'h0;
    repeat (20) @(posedge clk);
    chk(n_abort == ea && busy === 1'h0, "watchdog outcome");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    wb(8'h50, 1'h0, 8'h0, 8'h00, 1'h0);
    wb(8'h54, 1'h0, 8'h0, 8'h00, 1'h0);
    chk(lvl === 1'h0, "strapped level pin");
    wb(8'h58, 1'h0, 8'h0, 8'hFE, 1'h0);
    wb(8'h5C, 1'h0, 8'h0, 8'h00, 1'h1);
    wb(8'h54, 1'h1, 8'h01, 8'h0, 1'h0);
    wb(8'h54, 1'h0, 8'h0, 8'h00, 1'h0);
    wb(8'h54, 1'h1, 8'hB5, 8'h0, 1'h0);
    wb(8'h54, 1'h0, 8'h0, 8'h01, 1'h0);
    for (i = 0; i < 2; i++) begin
      wb(8'h54, 1'h1, 8'hB6, 8'h0, 1'h0);
      wb(8'h54, 1'h0, 8'h0, 8'h00, 1'h0);
      chk(lvl === 1'h0, "level pin after clear key");
      wb(8'h04, 1'h1, 8'h01 << i, 8'h0, 1'h0);
      wb(8'h54, 1'h0, 8'h0, 8'h01, 1'h0);
      chk(lvl === 1'h1 && n_drst == i + 1, "digital reset level");
    end
    for (i = 0; i < 8; i++) begin
      wb(8'h50, 1'h1, {5'h0, i[1:0], i[2]}, 8'h0, 1'h0);
      wb(8'h50, 1'h0, 8'h0, {5'h0, i[1:0], i[2]}, 1'h0);
      chk(osc === osc_exp[i] && st_en === i[2], "oscillator select");
    end
    vid <= 1'h1;
    wb(8'h50, 1'h1, 8'h04, 8'h0, 1'h0);
    wb(8'h50, 1'h0, 8'h0, 8'h04, 1'h0);
    chk(osc === 3'h5, "video clock select");
    vid <= 1'h0;
    ovr <= 1'h0;
    wb(8'h50, 1'h0, 8'h0, 8'h04, 1'h0);
    chk(osc === 3'h5, "fallback disabled select");
    ovr <= 1'h1;
    wb(8'h50, 1'h0, 8'h0, 8'h04, 1'h0);
    chk(osc === 3'h4, "video lost select");
    wb(8'h58, 1'h1, 8'h02, 8'h0, 1'h0);
    txn(8'h02, 0);
    txn(8'h00, 1);
    wb(8'h58, 1'h1, 8'h03, 8'h0, 1'h0);
    txn(8'h00, 1);
    wb(8'h58, 1'h1, 8'h04, 8'h0, 1'h0);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    wb(8'hC0, 1'h0, 8'h0, 8'h02, 1'h0);
    repeat (20) @(posedge clk);
    chk(n_abort == 2 && busy === 1'h0, "two-step timeout abort");
    wb(8'hC0, 1'h0, 8'h0, 8'h00, 1'h0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // test_test_clock_level_watchdog_regs
`default_nettype wire
